// File: bench/scp_host_model.sv
// host register writer model facing the selector
`timescale 1ns/1ps

module scp_host_model
(
  input wire logic ref_clk, // system clock
  input wire logic go, // request a one-word write
  input wire logic [4:0] addr, // address of the requested word
  input wire logic [10:0] data, // data of the requested word
  input wire logic clear_req, // request the register reset pin
  output logic reg_write, // one-cycle write pulse
  output logic [4:0] reg_addr, // address held with the pulse
  output logic [10:0] reg_data, // data held with the pulse
  output logic reg_reset_pin // reset pin, follows clear_req one cycle later
);
  // ****************************************************************
  // write and reset sequencing
  // ****************************************************************
  initial
  begin
    reg_write = 1'h0;
    reg_addr = 5'h1F;
    reg_data = 11'h7FF;
    reg_reset_pin = 1'h1;
  end
  // idle bus toggles each cycle between the inverse of the last word and the word itself
  always @(posedge ref_clk)
  begin
    reg_write <= go;
    reg_addr <= go ? addr : ~reg_addr;
    reg_data <= go ? data : ~reg_data;
    reg_reset_pin <= clear_req;
  end
endmodule

// File: bench/tb.sv
// self-checking testbench for the configuration selector
`timescale 1ns/1ps

module tb;
  import scp_pkg::*;
  // ****************************************************************
  // stimulus and observed signals
  // ****************************************************************
  logic ref_clk = 1'h0, nrst = 1'h0, serial_mode = 1'h0, power_down_pin = 1'h0;
  logic [1:0] interface_width_strap = 2'h0, serialize_factor_strap = 2'h0;
  logic [1:0] bit_order_format_strap = 2'h0, serial_select_gain_ref_strap = 2'h0;
  logic [1:0] reg_patterns = 2'h0, reg_interface_width = 2'h0;
  logic [1:0] reg_serialize_factor = 2'h0, reg_bit_order_format = 2'h0;
  logic serial_clock_pattern_strap = 1'h0, serial_data_pattern_strap = 1'h0;
  logic reg_override = 1'h0, reg_coarse_gain = 1'h0, reg_ref_internal = 1'h0;
  logic reg_global_pdn = 1'h0, go = 1'h0, clear_req = 1'h1;
  logic [4:0] addr = 5'h00;
  logic [10:0] data = 11'h000;
  logic reg_write, reg_reset_pin;
  logic [4:0] reg_addr;
  logic [10:0] reg_data;
  logic override_q, global_pdn_q, channels_enable_q, refs_enable_q, pll_enable_q;
  logic out_buf_enable_q, coarse_gain_q, ref_internal_q, two_wire_q, ddr_clock_q;
  logic ser16_q, rising_capture_q, lsb_first_q, offset_binary_q;
  scp_pattern_type pattern_q;
  int n_fail = 0;
  int comparisons = 0;

  always #5 ref_clk = ~ref_clk; // 100 MHz

  scp_host_model u_scp_host_model (.ref_clk, .go, .addr, .data, .clear_req, .reg_write,
    .reg_addr, .reg_data, .reg_reset_pin);

  scp_select u_scp_select (.ref_clk, .nrst, .serial_mode, .power_down_pin,
    .interface_width_strap, .serialize_factor_strap, .reserved_strap(2'h0),
    .bit_order_format_strap, .serial_select_gain_ref_strap, .serial_clock_pattern_strap,
    .serial_data_pattern_strap, .reg_write, .reg_addr, .reg_data, .reg_reset_pin,
    .reg_override, .reg_coarse_gain, .reg_ref_internal, .reg_global_pdn, .reg_patterns,
    .reg_interface_width, .reg_serialize_factor, .reg_bit_order_format, .override_q,
    .global_pdn_q, .channels_enable_q, .refs_enable_q, .pll_enable_q, .out_buf_enable_q,
    .coarse_gain_q, .ref_internal_q, .pattern_q, .two_wire_q, .ddr_clock_q, .ser16_q,
    .rising_capture_q, .lsb_first_q, .offset_binary_q);

  // ****************************************************************
  // shared helpers
  // ****************************************************************
  // all outputs packed so one compare covers the whole setting
  function automatic logic [15:0] obs();
    return {override_q, global_pdn_q, channels_enable_q, refs_enable_q, pll_enable_q,
      out_buf_enable_q, coarse_gain_q, ref_internal_q, pattern_q, two_wire_q, ddr_clock_q,
      ser16_q, rising_capture_q, lsb_first_q, offset_binary_q};
  endfunction
  // expected outputs from override, power down, gain, reference and level codes
  function automatic logic [15:0] want(input logic o, p, g, r, input logic [1:0] t, w, s, f);
    logic two, ddr;
    two = (w >= 2'h2);
    ddr = (w != 2'h2);
    return {o, p, {4{~p}}, g, r, t, two, ddr, (s == 2'h1 || s == 2'h2),
      (two && !ddr && s >= 2'h2), f[1], (f == 2'h1 || f == 2'h2)};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: outputs %h expected %h", $time, seen, exp);
    end
  endtask
  // outputs follow one cycle after inputs; three edges leave margin
  task automatic settle();
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic write_word(input logic [4:0] a, input logic [10:0] d);
    @(posedge ref_clk);
    go <= 1'h1;
    addr <= a;
    data <= d;
    @(posedge ref_clk);
    go <= 1'h0;
    settle();
  endtask
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  // every code of the three configuration straps, straps only
  task automatic t_cfg_straps();
    for (int w = 0; w < 4; w++)
      for (int s = 0; s < 4; s++)
      begin
        @(posedge ref_clk);
        interface_width_strap <= w[1:0];
        serialize_factor_strap <= s[1:0];
        bit_order_format_strap <= s[1:0];
        settle();
        check(obs(), want(0, 0, 0, 0, 2'h0, w[1:0], s[1:0], s[1:0]));
      end
    $display("cfg straps test done");
  endtask
  // enable strap levels, then the clock and data pair
  task automatic t_ctl_straps();
    for (int e = 0; e < 4; e++)
    begin
      @(posedge ref_clk);
      serial_select_gain_ref_strap <= e[1:0];
      settle();
      check(obs(), want(0, 0, e == 1 || e == 2, e[1], 2'h0, 2'h3, 2'h3, 2'h3));
    end
    for (int p = 0; p < 4; p++)
    begin
      @(posedge ref_clk);
      {serial_clock_pattern_strap, serial_data_pattern_strap} <= p[1:0];
      settle();
      check(obs(), want(0, p == 2, 0, 1, (p == 1) ? 2'h1 : (p == 3) ? 2'h2 : 2'h0,
        2'h3, 2'h3, 2'h3));
    end
    $display("ctl straps test done");
  endtask
  // combined mode: pin priority, gain held at 0 dB, reference from register
  task automatic t_pdn_pin();
    for (int k = 0; k < 4; k++)
    begin
      @(posedge ref_clk);
      serial_mode <= 1'h1;
      serial_select_gain_ref_strap <= 2'h2;
      {serial_clock_pattern_strap, serial_data_pattern_strap} <= 2'h2;
      {power_down_pin, reg_global_pdn} <= k[1:0];
      {reg_coarse_gain, reg_ref_internal, reg_patterns} <= {1'h1, k[0], k[1:0]};
      settle();
      check(obs(), want(0, k != 0, 0, k[0], k[1:0],
        2'h3, 2'h3, 2'h3));
    end
    $display("power down pin test done");
  endtask
  // override write, wrong address, soft reset and reset pin
  task automatic t_override();
    @(posedge ref_clk);
    {power_down_pin, reg_global_pdn} <= 2'h0;
    reg_patterns <= 2'h2;
    {reg_interface_width, reg_serialize_factor, reg_bit_order_format} <= 6'h2D;
    write_word(5'h0C, 11'h400);
    check(obs(), want(0, 0, 0, 1, 2'h2, 2'h3, 2'h3, 2'h3));
    write_word(ADDR_OVERRIDE_REG, 11'h400);
    check(obs(), want(1, 0, 1, 1, 2'h2, 2'h2, 2'h3, 2'h1));
    write_word(ADDR_RESET_REG, 11'h400);
    check(obs(), want(0, 0, 0, 1, 2'h2, 2'h3, 2'h3, 2'h3));
    write_word(ADDR_OVERRIDE_REG, 11'h400);
    check(obs(), want(1, 0, 1, 1, 2'h2, 2'h2, 2'h3, 2'h1));
    @(posedge ref_clk);
    clear_req <= 1'h1;
    @(posedge ref_clk);
    clear_req <= 1'h0;
    settle();
    check(obs(), want(0, 0, 0, 1, 2'h2, 2'h3, 2'h3, 2'h3));
    $display("override test done");
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial
  begin
    repeat (2) @(posedge ref_clk);
    #1;
    check(obs(), want(0, 0, 0, 0, 2'h0, 2'h0, 2'h0, 2'h0));
    repeat (3) @(posedge ref_clk);
    nrst <= 1'h1;
    clear_req <= 1'h0;
    settle();
    t_cfg_straps();
    t_ctl_straps();
    t_pdn_pin();
    t_override();
    give_verdict();
  end
  // the whole run needs well under a thousand cycles
  initial
  begin
    #100000;
    n_fail++;
    give_verdict();
  end
endmodule

// File: rtl/scp_pkg.sv
// constants shared by the strap and register configuration selector
package scp_pkg;

  // ****************************************************************
  // strap quantizer codes, ground upward
  // ****************************************************************
  localparam logic [1:0] LVL_GND = 2'h0; // ground
  localparam logic [1:0] LVL_LOW = 2'h1; // three-eighths or half supply
  localparam logic [1:0] LVL_HIGH = 2'h2; // five-eighths or five-sixths supply
  localparam logic [1:0] LVL_FULL = 2'h3; // full supply

  // ****************************************************************
  // register positions used by the selector
  // ****************************************************************
  localparam logic [4:0] ADDR_RESET_REG = 5'h00; // soft reset register
  localparam logic [4:0] ADDR_OVERRIDE_REG = 5'h0D; // override register
  localparam int OVERRIDE_BIT = 10; // override bit position
  localparam int SOFT_RESET_BIT = 10; // soft reset bit position

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic RST_OVERRIDE = 1'h0; // straps decide after reset
  localparam logic RST_GAIN = 1'h0; // 0 dB
  localparam logic RST_REF = 1'h0; // external reference
  localparam logic RST_PDN = 1'h0; // powered up
  localparam logic [1:0] RST_PATTERN = 2'h0; // normal conversion
  localparam logic [1:0] RST_CFG = 2'h0; // ground level codes

  // ****************************************************************
  // output test pattern selection
  // ****************************************************************
  typedef enum logic [1:0] {
    SCP_PAT_NORMAL,
    SCP_PAT_SYNC,
    SCP_PAT_DESKEW,
    SCP_PAT_OTHER
  } scp_pattern_type;

endpackage

// File: rtl/scp_select.sv
// configuration selector between board straps and serial register bits
// Operation
// - straps configure device after power-up, no reset
// - override high lets registers replace first, second and fourth straps
// - power-down pin high forces global power down
// - combined mode gain needs override, else 0dB
// - combined mode reference from register bit only
// - combined mode patterns and power down from registers
// - strap-only clock/data pair picks pattern or power
// - global power down disables everything together
// - enable strap selects reference and coarse gain
// - first strap selects bit clock rate, width
// - second strap selects serialization and edge
// - fourth strap selects bit order and format
// - override is bit 10 of register 0x0D
// - soft reset restores defaults then self-clears
`timescale 1ns/1ps

module scp_select
  import scp_pkg::*;
(
  input wire logic ref_clk, // system clock, 100 MHz
  input wire logic nrst, // asynchronous reset, active low
  input wire logic serial_mode, // high: serial registers in use with straps
  input wire logic power_down_pin, // dedicated global power-down pin
  input wire logic [1:0] interface_width_strap, // quantized first strap
  input wire logic [1:0] serialize_factor_strap, // quantized second strap
  input wire logic [1:0] reserved_strap, // quantized third strap, unused
  input wire logic [1:0] bit_order_format_strap, // quantized fourth strap
  input wire logic [1:0] serial_select_gain_ref_strap, // quantized enable strap
  input wire logic serial_clock_pattern_strap, // clock pin level in strap mode
  input wire logic serial_data_pattern_strap, // data pin level in strap mode
  input wire logic reg_write, // one-cycle pulse: register word written
  input wire logic [4:0] reg_addr, // register address of the word
  input wire logic [10:0] reg_data, // register data of the word
  input wire logic reg_reset_pin, // register reset pin, active high
  input wire logic reg_override, // override register bit value
  input wire logic reg_coarse_gain, // coarse gain register bit
  input wire logic reg_ref_internal, // reference select register bit
  input wire logic reg_global_pdn, // global power-down register bit
  input wire logic [1:0] reg_patterns, // test pattern register field
  input wire logic [1:0] reg_interface_width, // register replacement, first strap
  input wire logic [1:0] reg_serialize_factor, // register replacement, second strap
  input wire logic [1:0] reg_bit_order_format, // register replacement, fourth strap
  output logic override_q, // held override bit
  output logic global_pdn_q, // global power down of all blocks
  output logic channels_enable_q, // converter channels enabled
  output logic refs_enable_q, // internal references enabled
  output logic pll_enable_q, // clock-multiplying loop enabled
  output logic out_buf_enable_q, // output buffers enabled
  output logic coarse_gain_q, // 1: 3.5 dB, 0: 0 dB
  output logic ref_internal_q, // 1: internal reference
  output scp_pattern_type pattern_q, // output pattern selection
  output logic two_wire_q, // 1: two-wire output
  output logic ddr_clock_q, // 1: double-rate bit clock
  output logic ser16_q, // 1: 16x, 0: 14x serialization
  output logic rising_capture_q, // 1: rising-edge capture
  output logic lsb_first_q, // 1: LSB first
  output logic offset_binary_q // 1: offset binary, 0: two's complement
);

  // ****************************************************************
  // held override bit with soft and pin reset
  // ****************************************************************
  logic override_d; // next override value
  logic soft_reset; // one-cycle soft reset request

  // soft reset is a write with bit 10 set; the bit itself is never stored,
  // so it reads back low the cycle after
  always_comb
  begin
    soft_reset = reg_write && (reg_addr == ADDR_RESET_REG) && reg_data[SOFT_RESET_BIT];
    override_d = override_q;
    if (reg_reset_pin || soft_reset)
    begin
      override_d = RST_OVERRIDE; // defaults restored
    end
    else if (reg_write && (reg_addr == ADDR_OVERRIDE_REG))
    begin
      override_d = reg_data[OVERRIDE_BIT];
    end
    else if (!reg_write)
    begin
      override_d = override_q | (reg_override & 1'h0); // hold
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      override_q <= RST_OVERRIDE;
    end
    else
    begin
      override_q <= override_d;
    end
  end

  // ****************************************************************
  // selection of every function
  // ****************************************************************
  logic pdn_d; // next global power down
  logic gain_d; // next coarse gain
  logic ref_d; // next reference select
  scp_pattern_type pat_d; // next pattern
  logic [1:0] w_code; // effective first strap code
  logic [1:0] s_code; // effective second strap code
  logic [1:0] f_code; // effective fourth strap code
  logic two_wire_d; // next two-wire
  logic ddr_d; // next double rate
  logic ser16_d; // next 16x
  logic rise_d; // next rising capture
  logic lsb_d; // next lsb first
  logic ob_d; // next offset binary

  // straps are static level codes, so they are decoded directly each cycle
  // and no reset sequence is needed to configure after power-up
  always_comb
  begin
    // strap or register code per override
    w_code = override_q ? reg_interface_width : interface_width_strap;
    s_code = override_q ? reg_serialize_factor : serialize_factor_strap;
    f_code = override_q ? reg_bit_order_format : bit_order_format_strap;
    // first strap, half-supply level is unused and kept as default
    case (w_code)
      LVL_HIGH:
      begin
        two_wire_d = 1'h1;
        ddr_d = 1'h0;
      end
      LVL_FULL:
      begin
        two_wire_d = 1'h1;
        ddr_d = 1'h1;
      end
      default:
      begin
        two_wire_d = 1'h0;
        ddr_d = 1'h1;
      end
    endcase
    // second strap
    ser16_d = (s_code == LVL_LOW) || (s_code == LVL_HIGH);
    // edge only matters in two-wire single rate
    rise_d = (s_code[1]) && two_wire_d && !ddr_d;
    // fourth strap
    lsb_d = f_code[1];
    ob_d = (f_code == LVL_LOW) || (f_code == LVL_HIGH);
    if (serial_mode)
    begin
      gain_d = override_q ? reg_coarse_gain : 1'h0;
      ref_d = reg_ref_internal;
      pat_d = scp_pattern_type'(reg_patterns);
      pdn_d = reg_global_pdn;
    end
    else
    begin
      // enable strap
      gain_d = (serial_select_gain_ref_strap == LVL_LOW) ||
               (serial_select_gain_ref_strap == LVL_HIGH);
      ref_d = serial_select_gain_ref_strap[1];
      // clock/data pair
      case ({serial_clock_pattern_strap, serial_data_pattern_strap})
        2'h1: pat_d = SCP_PAT_SYNC;
        2'h3: pat_d = SCP_PAT_DESKEW;
        default: pat_d = SCP_PAT_NORMAL;
      endcase
      pdn_d = (serial_clock_pattern_strap && !serial_data_pattern_strap);
    end
    if (power_down_pin)
    begin
      pdn_d = 1'h1; // pin wins
    end
  end

  // registered outputs; power down gates all blocks together
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      global_pdn_q <= RST_PDN;
      channels_enable_q <= 1'h1;
      refs_enable_q <= 1'h1;
      pll_enable_q <= 1'h1;
      out_buf_enable_q <= 1'h1;
      coarse_gain_q <= RST_GAIN;
      ref_internal_q <= RST_REF;
      pattern_q <= SCP_PAT_NORMAL;
      two_wire_q <= 1'h0;
      ddr_clock_q <= 1'h1;
      ser16_q <= 1'h0;
      rising_capture_q <= 1'h0;
      lsb_first_q <= 1'h0;
      offset_binary_q <= 1'h0;
    end
    else
    begin
      global_pdn_q <= pdn_d;
      channels_enable_q <= !pdn_d;
      refs_enable_q <= !pdn_d;
      pll_enable_q <= !pdn_d;
      out_buf_enable_q <= !pdn_d;
      coarse_gain_q <= gain_d;
      ref_internal_q <= ref_d;
      pattern_q <= pat_d;
      two_wire_q <= two_wire_d;
      ddr_clock_q <= ddr_d;
      ser16_q <= ser16_d;
      rising_capture_q <= rise_d;
      lsb_first_q <= lsb_d;
      offset_binary_q <= ob_d;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // power-down pin raised
  sequence pin_high_s;
    power_down_pin;
  endsequence

  // straps alone decide the control functions
  sequence strap_mode_s;
    !serial_mode;
  endsequence

  // soft reset word with its reset bit set
  sequence soft_write_s;
    reg_write && (reg_addr == ADDR_RESET_REG) && reg_data[SOFT_RESET_BIT];
  endsequence

  // override word written while the reset pin is released
  sequence ovrd_write_s;
    reg_write && (reg_addr == ADDR_OVERRIDE_REG) && !reg_reset_pin;
  endsequence

  // override set by a write, then one cycle for the held bit to show
  sequence ovrd_taken_s;
    reg_write && (reg_addr == ADDR_OVERRIDE_REG) && !reg_reset_pin && reg_data[OVERRIDE_BIT]
      ##1 1'h1;
  endsequence

  // power down priority and fan-out
  pin_pdn_a: assert property (pin_high_s |=> global_pdn_q)
    else $error("power-down pin did not force power down");
  pdn_all_a: assert property (global_pdn_q |-> !channels_enable_q
    && !refs_enable_q && !pll_enable_q && !out_buf_enable_q)
    else $error("power down left a block enabled");
  pdn_reg_a: assert property (serial_mode && !power_down_pin
    |=> global_pdn_q == $past(reg_global_pdn))
    else $error("register power down ignored with pin low");

  // combined mode: gain held at 0 dB without override, reference and patterns from registers
  gain_ovrd_a: assert property (serial_mode && !override_q |=> !coarse_gain_q)
    else $error("gain applied without override");
  ref_reg_a: assert property (serial_mode
    |=> ref_internal_q == $past(reg_ref_internal))
    else $error("reference not from register");
  pat_reg_a: assert property (serial_mode
    |=> pattern_q == scp_pattern_type'($past(reg_patterns)))
    else $error("pattern not from register");

  // override bit writes and soft reset
  soft_rst_a: assert property (soft_write_s |=> !override_q)
    else $error("soft reset kept override");
  ovrd_wr_a: assert property (ovrd_write_s
    |=> override_q == $past(reg_data[OVERRIDE_BIT]))
    else $error("override write lost");
  reg_take_a: assert property (ovrd_taken_s
    |=> offset_binary_q == $past((reg_bit_order_format == LVL_LOW)
    || (reg_bit_order_format == LVL_HIGH)))
    else $error("register code not used after override write");
  reg_sel_a: assert property (override_q
    |=> lsb_first_q == $past(reg_bit_order_format[1]))
    else $error("register code not used with override high");
  strap_sel_a: assert property (!override_q
    |=> lsb_first_q == $past(bit_order_format_strap[1]))
    else $error("strap not used with override low");

  // strap decodes
  pair_pdn_a: assert property (!serial_mode && serial_clock_pattern_strap
    && !serial_data_pattern_strap |=> global_pdn_q)
    else $error("strap pair did not power down");
  sync_pair_a: assert property (!serial_mode && !serial_clock_pattern_strap
    && serial_data_pattern_strap |=> pattern_q == SCP_PAT_SYNC)
    else $error("strap pair did not select sync");
  gain_strap_a: assert property (strap_mode_s
    |=> coarse_gain_q == $past((serial_select_gain_ref_strap == LVL_LOW)
    || (serial_select_gain_ref_strap == LVL_HIGH)))
    else $error("enable strap gain decode wrong");
  ref_strap_a: assert property (strap_mode_s
    |=> ref_internal_q == $past(serial_select_gain_ref_strap[1]))
    else $error("enable strap reference decode wrong");
  width_dec_a: assert property (!override_q && interface_width_strap == LVL_HIGH
    |=> two_wire_q && !ddr_clock_q)
    else $error("first strap decode wrong");
  ser_dec_a: assert property (!override_q && serialize_factor_strap == LVL_GND
    |=> !ser16_q && !rising_capture_q)
    else $error("second strap decode wrong");
  edge_ddr_a: assert property (ddr_clock_q |-> !rising_capture_q)
    else $error("capture edge set outside single rate");
  fmt_dec_a: assert property (!override_q && bit_order_format_strap == LVL_FULL
    |=> lsb_first_q && !offset_binary_q)
    else $error("fourth strap decode wrong");

endmodule
